// ---- pkg/std_timer_pkg.sv ----
package std_timer_pkg;
   // register byte addresses, one aligned word each
   localparam logic [7:0] OFF_CONTROL_ZERO  = 8'h00; // run, mode
   localparam logic [7:0] OFF_CONTROL_ONE   = 8'h04; // output and clear control
   localparam logic [7:0] OFF_COUNTER_LOW   = 8'h08;
   localparam logic [7:0] OFF_COUNTER_HIGH  = 8'h0C;
   localparam logic [7:0] OFF_COMPARE_A_LOW = 8'h10;
   localparam logic [7:0] OFF_COMPARE_A_HIGH = 8'h14;
   localparam logic [7:0] OFF_COMPARE_P     = 8'h18;
   localparam logic [7:0] OFF_STATUS        = 8'h1C; // pin level before inversion, read only

   // control zero fields
   localparam int RUN_BIT       = 3;
   localparam int MODE_LSB      = 4;
   // control one fields
   localparam int CLEAR_SEL_BIT = 0;
   localparam int SWAP_BIT      = 1;
   localparam int INVERT_BIT    = 2;
   localparam int LEVEL_BIT     = 3;
   localparam int FUNC_LSB      = 4;

   localparam logic [7:0]  RESET_BYTE    = 8'h00;
   localparam logic [15:0] RESET_COUNTER = 16'h0000;

   // operating modes
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } mode_type;

   // output functions in compare mode
   localparam logic [1:0] FUNC_NONE   = 2'b00;
   localparam logic [1:0] FUNC_LOW    = 2'b01;
   localparam logic [1:0] FUNC_HIGH   = 2'b10;
   localparam logic [1:0] FUNC_TOGGLE = 2'b11;
   // output functions in pwm mode
   localparam logic [1:0] FUNC_INACTIVE = 2'b00;
   localparam logic [1:0] FUNC_ACTIVE   = 2'b01;
   localparam logic [1:0] FUNC_PWM      = 2'b10;
endpackage : std_timer_pkg

// ---- src/standard_timer_output_ctrl.sv ----
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - compare mode: level bit sets initial pin
// - pwm mode: level bit is active level
// - invert bit inverts the pin
// - timer/counter mode ignores level and invert
// - swap bit exchanges period and duty comparators
// - clear select 1: clear on A match
// - clear select 0: clear on P match/overflow
// - outside capture mode, overflow clear only when P is zero
// - clear select ignored in pwm, capture
// - counter readable as two reset-zero bytes
// - compare A held in two rw bytes
// - run rising edge loads initial pin level
// - P compared against upper counter byte
module standard_timer_output_ctrl (
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             timer_out_pin_a_o,
   output logic             timer_out_enable_n_o,
   output logic             match_a_o,
   output logic             match_p_o
);
   // software registers
   logic [7:0]  control_zero;          // run and mode
   logic [7:0]  control_one;           // output and clear control
   logic [7:0]  compare_a_low_byte;    // compare a bits 7..0
   logic [7:0]  compare_a_high_byte;   // compare a bits 15..8
   logic [7:0]  compare_p_value;       // compare p, 8 bits
   logic [15:0] counter;               // internal up counter
   logic        run_last;              // run bit of previous cycle
   logic        pin_state;             // pin before inversion
   logic [15:0] next_counter;
   logic        next_pin_state;

   // field decoding
   wire std_timer_pkg::mode_type mode =
      std_timer_pkg::mode_type'(control_zero[std_timer_pkg::MODE_LSB +: 2]);
   wire       timer_run            = control_zero[std_timer_pkg::RUN_BIT];
   wire       counter_clear_select = control_one[std_timer_pkg::CLEAR_SEL_BIT];
   wire       period_duty_swap     = control_one[std_timer_pkg::SWAP_BIT];
   wire       output_invert        = control_one[std_timer_pkg::INVERT_BIT];
   wire       output_level_ctrl    = control_one[std_timer_pkg::LEVEL_BIT];
   wire [1:0] output_function      = control_one[std_timer_pkg::FUNC_LSB +: 2];
   wire [15:0] compare_a_value     = {compare_a_high_byte, compare_a_low_byte};

   // comparators
   wire match_a   = timer_run && (counter == compare_a_value);
   // period of P blocks of 256 ends one count short of P*256; zero wraps to 16'hFFFF
   wire [7:0] p_last = compare_p_value - 8'h01;                           // last period block
   wire match_p   = timer_run && (counter[15:8] == p_last)
                    && (counter[7:0] == 8'hFF);
   wire p_is_zero = (compare_p_value == 8'h00);
   wire overflow  = timer_run && (counter == 16'hFFFF);
   wire pwm_mode  = (mode == std_timer_pkg::MODE_PWM);
   wire run_rise  = timer_run && !run_last;

   // period and duty sources in pwm
   wire period_end = period_duty_swap ? match_a
                                      : (p_is_zero ? overflow : match_p);
   wire [15:0] duty_value = period_duty_swap ? {compare_p_value, 8'h00}
                                             : compare_a_value;
   wire pwm_active = (counter < duty_value);

   // clear source; select bit only counts outside pwm and capture
   wire clear_on_p = p_is_zero ? overflow : match_p;
   wire compare_like = (mode == std_timer_pkg::MODE_COMPARE) ||
                       (mode == std_timer_pkg::MODE_TIMER);
   wire clear_hit = pwm_mode ? period_end :
                    !compare_like ? overflow :
                    counter_clear_select ? match_a :
                    clear_on_p;

   // counter next value
   always_comb begin
      if (!timer_run) begin
         next_counter = counter;            // paused counter holds its value
      end else if (clear_hit) begin
         next_counter = std_timer_pkg::RESET_COUNTER;
      end else begin
         next_counter = counter + 16'h0001;
      end
   end

   // output pin state before inversion
   always_comb begin
      next_pin_state = pin_state;
      if (run_rise) begin
         next_pin_state = output_level_ctrl;
      end else if (mode == std_timer_pkg::MODE_COMPARE && match_a) begin
         case (output_function)
            std_timer_pkg::FUNC_LOW:    next_pin_state = 1'b0;
            std_timer_pkg::FUNC_HIGH:   next_pin_state = 1'b1;
            std_timer_pkg::FUNC_TOGGLE: next_pin_state = !pin_state;
            default:                    next_pin_state = pin_state;
         endcase
      end else if (pwm_mode) begin
         // level bit names the active level; pulse polarity follows it
         case (output_function)
            std_timer_pkg::FUNC_INACTIVE: next_pin_state = !output_level_ctrl;
            std_timer_pkg::FUNC_ACTIVE:   next_pin_state = output_level_ctrl;
            std_timer_pkg::FUNC_PWM:
               next_pin_state = pwm_active ? output_level_ctrl : !output_level_ctrl;
            default:                      next_pin_state = !output_level_ctrl;
         endcase
      end
   end

   // timer state registers
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         counter   <= std_timer_pkg::RESET_COUNTER;
         run_last  <= 1'b0;
         pin_state <= 1'b0;
      end else begin
         counter   <= next_counter;
         run_last  <= timer_run;
         pin_state <= next_pin_state;
      end
   end

   // pin drive: timer/counter mode leaves the pin to other functions
   wire drives_pin = (mode == std_timer_pkg::MODE_COMPARE) || pwm_mode;
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         timer_out_pin_a_o    <= 1'b0;
         timer_out_enable_n_o <= 1'b1;
      end else begin
         timer_out_pin_a_o    <= drives_pin ? (pin_state ^ output_invert) : 1'b0;
         timer_out_enable_n_o <= !drives_pin;
      end
   end

   assign match_a_o = match_a;
   assign match_p_o = match_p;

   // apb slave, zero wait states
   wire apb_access = psel_i && penable_i;
   wire apb_write  = apb_access && pwrite_i;
   wire mapped     = (paddr_i <= std_timer_pkg::OFF_STATUS) && (paddr_i[1:0] == 2'b00);
   wire wr_ctl0    = apb_write && (paddr_i == std_timer_pkg::OFF_CONTROL_ZERO);
   wire wr_ctl1    = apb_write && (paddr_i == std_timer_pkg::OFF_CONTROL_ONE);
   wire wr_a_low   = apb_write && (paddr_i == std_timer_pkg::OFF_COMPARE_A_LOW);
   wire wr_a_high  = apb_write && (paddr_i == std_timer_pkg::OFF_COMPARE_A_HIGH);
   wire wr_p       = apb_write && (paddr_i == std_timer_pkg::OFF_COMPARE_P);
   assign pready_o  = 1'b1;
   assign pslverr_o = apb_access && !mapped;  // unmapped address answers an error

   // register writes; counter bytes are read only and ignore writes
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         control_zero        <= std_timer_pkg::RESET_BYTE;
         control_one         <= std_timer_pkg::RESET_BYTE;
         compare_a_low_byte  <= std_timer_pkg::RESET_BYTE;
         compare_a_high_byte <= std_timer_pkg::RESET_BYTE;
         compare_p_value     <= std_timer_pkg::RESET_BYTE;
      end else begin
         if (wr_ctl0)   control_zero        <= pwdata_i[7:0];
         if (wr_ctl1)   control_one         <= pwdata_i[7:0];
         if (wr_a_low)  compare_a_low_byte  <= pwdata_i[7:0];
         if (wr_a_high) compare_a_high_byte <= pwdata_i[7:0];
         if (wr_p)      compare_p_value     <= pwdata_i[7:0];
      end
   end

   // read mux, registered in the setup cycle so data is ready at access
   logic [7:0] read_byte;
   always_comb begin
      case (paddr_i)
         std_timer_pkg::OFF_CONTROL_ZERO:   read_byte = control_zero;
         std_timer_pkg::OFF_CONTROL_ONE:    read_byte = control_one;
         std_timer_pkg::OFF_COUNTER_LOW:    read_byte = counter[7:0];
         std_timer_pkg::OFF_COUNTER_HIGH:   read_byte = counter[15:8];
         std_timer_pkg::OFF_COMPARE_A_LOW:  read_byte = compare_a_low_byte;
         std_timer_pkg::OFF_COMPARE_A_HIGH: read_byte = compare_a_high_byte;
         std_timer_pkg::OFF_COMPARE_P:      read_byte = compare_p_value;
         std_timer_pkg::OFF_STATUS:         read_byte = {7'h00, pin_state};
         default:                           read_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         prdata_o <= 32'h00000000;
      end else if (psel_i && !penable_i) begin
         prdata_o <= {24'h000000, read_byte};
      end
   end

   // checks; all on the timer clock, quiet while reset is held
   // counter clearing in compare, timer/counter, capture and pwm modes

   // select high: an A match clears
   a_clear_on_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (compare_like && counter_clear_select && match_a) |=> (counter == 16'h0000))
      else $error("counter not cleared on compare a match");

   // select high: a P match alone must not clear
   a_a_ignores_p: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (compare_like && counter_clear_select && match_p && !match_a)
      |=> (counter == $past(counter) + 16'h0001))
      else $error("counter cleared on p match with select high");

   // select low: a P match clears
   a_clear_on_p: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (compare_like && !counter_clear_select && !p_is_zero && match_p)
      |=> (counter == 16'h0000))
      else $error("counter not cleared on compare p match");

   // select low, nonzero P: nothing but its match clears
   a_no_wrap_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (compare_like && !counter_clear_select && !p_is_zero && timer_run && !match_p)
      |=> (counter == $past(counter) + 16'h0001))
      else $error("counter cleared without p match");

   // P match lands at the end of a 256 clock block
   a_p_block: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      match_p_o |-> ((counter[7:0] == 8'hFF) && (8'(counter[15:8] + 8'h01) == compare_p_value)))
      else $error("p match away from a block boundary");

   // capture mode clears on overflow only
   a_capture_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (mode == std_timer_pkg::MODE_CAPTURE && timer_run && !overflow)
      |=> (counter == $past(counter) + 16'h0001))
      else $error("capture mode counter cleared early");

   // pwm: select bit has no say, A is duty here
   a_pwm_ignores_sel: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (pwm_mode && counter_clear_select && !period_duty_swap && match_a && !match_p && !overflow)
      |=> (counter == $past(counter) + 16'h0001))
      else $error("pwm counter cleared by select bit");

   // swapped: A ends the period
   a_pwm_swap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (pwm_mode && period_duty_swap && match_a) |=> (counter == 16'h0000))
      else $error("swapped period not from compare a");

   // swapped: a P match is duty only
   a_swap_p_duty: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (pwm_mode && period_duty_swap && match_p && !match_a)
      |=> (counter == $past(counter) + 16'h0001))
      else $error("swapped p match cleared counter");

   // register side of the counter and compare A

   // paused counter keeps its value
   a_pause_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !timer_run |=> (counter == $past(counter)))
      else $error("paused counter moved");

   // counter bytes read live
   a_read_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (psel_i && !penable_i && paddr_i == std_timer_pkg::OFF_COUNTER_LOW)
      |=> (prdata_o == {24'h000000, $past(counter[7:0])}))
      else $error("counter low byte read wrong");

   a_read_high: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (psel_i && !penable_i && paddr_i == std_timer_pkg::OFF_COUNTER_HIGH)
      |=> (prdata_o == {24'h000000, $past(counter[15:8])}))
      else $error("counter high byte read wrong");

   // software cannot write the counter
   a_counter_ro: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (psel_i && penable_i && pwrite_i && !timer_run &&
       paddr_i == std_timer_pkg::OFF_COUNTER_LOW) |=> (counter == $past(counter)))
      else $error("counter changed by a write");

   // compare A bytes take written data
   a_write_a_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (psel_i && penable_i && pwrite_i && paddr_i == std_timer_pkg::OFF_COMPARE_A_LOW)
      |=> (compare_a_low_byte == $past(pwdata_i[7:0])))
      else $error("compare a low byte not written");

   a_write_a_high: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (psel_i && penable_i && pwrite_i && paddr_i == std_timer_pkg::OFF_COMPARE_A_HIGH)
      |=> (compare_a_high_byte == $past(pwdata_i[7:0])))
      else $error("compare a high byte not written");

   // match flag only on full equality
   a_match_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      match_a_o |-> (counter == compare_a_value))
      else $error("compare a match with unequal counter");

   // pin behaviour

   // run rise loads the initial level
   a_run_level: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(timer_run) |=> (pin_state == $past(output_level_ctrl)))
      else $error("initial level not loaded on run rise");

   // compare mode: pin keeps its level until an A match
   a_compare_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (mode == std_timer_pkg::MODE_COMPARE && timer_run && !run_rise && !match_a)
      |=> (pin_state == $past(pin_state)))
      else $error("compare pin moved without a match");

   // pwm forced active follows the level bit
   a_pwm_active: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (pwm_mode && timer_run && !run_rise && output_function == std_timer_pkg::FUNC_ACTIVE)
      |=> (pin_state == $past(output_level_ctrl)))
      else $error("pwm active level wrong");

   // pwm wave: active while counter is below A
   a_pwm_wave: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (pwm_mode && timer_run && !run_rise && !period_duty_swap &&
       output_function == std_timer_pkg::FUNC_PWM)
      |=> (pin_state == (($past(counter) < $past(compare_a_value)) ?
                         $past(output_level_ctrl) : !$past(output_level_ctrl))))
      else $error("pwm wave level wrong");

   // invert bit flips the driven pin
   a_invert_pin: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (drives_pin && $stable(output_invert))
      |=> (timer_out_pin_a_o == $past(pin_state ^ output_invert)))
      else $error("pin polarity wrong");

   // compare and pwm modes drive the pin
   a_pin_enable: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (mode == std_timer_pkg::MODE_COMPARE || pwm_mode) |=> !timer_out_enable_n_o)
      else $error("pin not driven in an output mode");

   // timer/counter mode leaves the pin alone
   a_timer_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (mode == std_timer_pkg::MODE_TIMER) |=> timer_out_enable_n_o && !timer_out_pin_a_o)
      else $error("pin driven in timer counter mode");
endmodule : standard_timer_output_ctrl

// ---- verification/tb_standard_timer_output_ctrl.sv ----
`timescale 1ns/1ps
module tb_standard_timer_output_ctrl;
   logic        clock_i;              // 100 MHz timer clock
   logic        reset_n_i;            // sync reset, active low
   logic        psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i;
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o;
   logic        timer_out_pin_a_o, timer_out_enable_n_o, match_a_o, match_p_o;
   int          bad_count, total_checks, cycles;
   logic [31:0] rd;                   // last read data
   logic        err;                  // last slave error
   int          na, np, nh;           // match and pin-high counts

   standard_timer_output_ctrl dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .timer_out_pin_a_o(timer_out_pin_a_o), .timer_out_enable_n_o(timer_out_enable_n_o),
      .match_a_o(match_a_o), .match_p_o(match_p_o));

   // free running clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // hang guard: tests need a few thousand cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      while (pready_o !== 1'b1) @(posedge clock_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check({31'h0, err}, {31'h0, eerr});
   endtask : rdchk

   task automatic do_reset();
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
   endtask : do_reset

   function automatic logic [31:0] ctl1(input logic cs, sw, inv, lvl, input logic [1:0] fn);
      ctl1 = 32'h0;
      ctl1[std_timer_pkg::CLEAR_SEL_BIT] = cs;
      ctl1[std_timer_pkg::SWAP_BIT] = sw;
      ctl1[std_timer_pkg::INVERT_BIT] = inv;
      ctl1[std_timer_pkg::LEVEL_BIT] = lvl;
      ctl1[std_timer_pkg::FUNC_LSB +: 2] = fn;
   endfunction : ctl1

   function automatic logic [31:0] ctl0(input logic run, input logic [1:0] md);
      ctl0 = 32'h0;
      ctl0[std_timer_pkg::RUN_BIT] = run;
      ctl0[std_timer_pkg::MODE_LSB +: 2] = md;
   endfunction : ctl0

   // set up comparators, control one, then start in the given mode
   task automatic start(input logic [7:0] p, input logic [15:0] a, input logic [31:0] c1,
                        input logic [1:0] md);
      do_reset();
      apb(1'b1, std_timer_pkg::OFF_COMPARE_P, {24'h0, p});
      apb(1'b1, std_timer_pkg::OFF_COMPARE_A_LOW, {24'h0, a[7:0]});
      apb(1'b1, std_timer_pkg::OFF_COMPARE_A_HIGH, {24'h0, a[15:8]});
      apb(1'b1, std_timer_pkg::OFF_CONTROL_ONE, c1);
      apb(1'b1, std_timer_pkg::OFF_CONTROL_ZERO, ctl0(1'b1, md));
   endtask : start

   // sampled mid-cycle so comb pulses are settled
   task automatic count(input int cyc);
      na = 0;
      np = 0;
      nh = 0;
      repeat (cyc) begin
         @(negedge clock_i);
         if (match_a_o === 1'b1) na++;
         if (match_p_o === 1'b1) np++;
         if (timer_out_pin_a_o === 1'b1) nh++;
      end
   endtask : count

   task automatic t_regs();
      rdchk(std_timer_pkg::OFF_COUNTER_LOW, 32'h0, 1'b0);
      rdchk(std_timer_pkg::OFF_COUNTER_HIGH, 32'h0, 1'b0);
      rdchk(std_timer_pkg::OFF_COMPARE_A_LOW, 32'h0, 1'b0);
      rdchk(std_timer_pkg::OFF_COMPARE_A_HIGH, 32'h0, 1'b0);
      apb(1'b1, std_timer_pkg::OFF_COMPARE_A_LOW, 32'h000000A5);
      apb(1'b1, std_timer_pkg::OFF_COMPARE_A_HIGH, 32'h0000005A);
      apb(1'b1, std_timer_pkg::OFF_COUNTER_LOW, 32'h000000FF);
      rdchk(std_timer_pkg::OFF_COMPARE_A_LOW, 32'h000000A5, 1'b0);
      rdchk(std_timer_pkg::OFF_COMPARE_A_HIGH, 32'h0000005A, 1'b0);
      rdchk(std_timer_pkg::OFF_COUNTER_LOW, 32'h0, 1'b0);
      rdchk(8'h20, 32'h0, 1'b1);                              // unmapped word
   endtask : t_regs

   // clear source: A match, overflow with P zero, P match every 256 clocks
   task automatic t_clear();
      start(8'h00, 16'h0010, ctl1(1'b1, 1'b0, 1'b0, 1'b0, 2'b00), std_timer_pkg::MODE_COMPARE);
      count(160);
      check(na, 9);
      start(8'h00, 16'h0010, ctl1(1'b0, 1'b0, 1'b0, 1'b0, 2'b00), std_timer_pkg::MODE_COMPARE);
      count(160);
      check(na, 1);
      start(8'h01, 16'hFFFF, ctl1(1'b0, 1'b0, 1'b0, 1'b0, 2'b00), std_timer_pkg::MODE_COMPARE);
      count(900);
      check(np, 3);
      check(na, 0);
   endtask : t_clear

   // initial level, match drive, inversion, reload on run rise, timer mode
   task automatic t_pin();
      for (int inv = 0; inv < 2; inv++) begin
         start(8'h00, 16'h0040, ctl1(1'b1, 1'b0, inv[0], 1'b1, std_timer_pkg::FUNC_LOW),
               std_timer_pkg::MODE_COMPARE);
         repeat (3) @(negedge clock_i);
         check(timer_out_pin_a_o, 1'b1 ^ inv[0]);
         check(timer_out_enable_n_o, 1'b0);
         repeat (80) @(negedge clock_i);
         check(timer_out_pin_a_o, 1'b0 ^ inv[0]);
         // stop, push A far away so no match interferes, restart
         apb(1'b1, std_timer_pkg::OFF_CONTROL_ZERO, ctl0(1'b0, std_timer_pkg::MODE_COMPARE));
         apb(1'b1, std_timer_pkg::OFF_COMPARE_A_HIGH, 32'h000000FF);
         apb(1'b1, std_timer_pkg::OFF_CONTROL_ZERO, ctl0(1'b1, std_timer_pkg::MODE_COMPARE));
         repeat (3) @(negedge clock_i);
         check(timer_out_pin_a_o, 1'b1 ^ inv[0]);
         apb(1'b1, std_timer_pkg::OFF_CONTROL_ZERO, ctl0(1'b1, std_timer_pkg::MODE_TIMER));
         repeat (3) @(negedge clock_i);
         check(timer_out_enable_n_o, 1'b1);
         check(timer_out_pin_a_o, 1'b0);
      end
   endtask : t_pin

   // pwm duty over one full 256 clock window
   task automatic t_pwm();
      start(8'h01, 16'h0040, ctl1(1'b1, 1'b0, 1'b0, 1'b1, std_timer_pkg::FUNC_PWM),
            std_timer_pkg::MODE_PWM);
      repeat (300) @(negedge clock_i);
      count(256);
      check(nh, 64);
      start(8'h01, 16'h0040, ctl1(1'b0, 1'b0, 1'b0, 1'b0, std_timer_pkg::FUNC_PWM),
            std_timer_pkg::MODE_PWM);
      repeat (300) @(negedge clock_i);
      count(256);
      check(nh, 192);
      start(8'h01, 16'h0080, ctl1(1'b0, 1'b1, 1'b0, 1'b1, std_timer_pkg::FUNC_PWM),
            std_timer_pkg::MODE_PWM);
      repeat (300) @(negedge clock_i);
      count(256);
      check(nh, 256);
   endtask : t_pwm

   // toggle in compare mode, overflow-only clearing in capture mode, fixed levels in pwm
   task automatic t_funcs();
      start(8'h00, 16'h0010, ctl1(1'b1, 1'b0, 1'b0, 1'b0, std_timer_pkg::FUNC_TOGGLE),
            std_timer_pkg::MODE_COMPARE);
      count(170);
      check(na, 10);
      check(nh, 84);
      start(8'h01, 16'h0010, ctl1(1'b1, 1'b0, 1'b0, 1'b0, 2'b00), std_timer_pkg::MODE_CAPTURE);
      count(300);
      check(na, 1);
      check(np, 1);
      start(8'h01, 16'h0040, ctl1(1'b0, 1'b0, 1'b0, 1'b1, std_timer_pkg::FUNC_ACTIVE),
            std_timer_pkg::MODE_PWM);
      repeat (4) @(negedge clock_i);
      count(256);
      check(nh, 256);
      apb(1'b1, std_timer_pkg::OFF_CONTROL_ONE,
          ctl1(1'b0, 1'b0, 1'b0, 1'b1, std_timer_pkg::FUNC_INACTIVE));
      repeat (4) @(negedge clock_i);
      count(256);
      check(nh, 0);
   endtask : t_funcs

   task automatic conclude();
      if (bad_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   initial begin
      reset_n_i = 1'b0;
      {psel_i, penable_i, pwrite_i} = 3'b000;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      t_regs();
      t_clear();
      t_pin();
      t_pwm();
      t_funcs();
      conclude();
   end
endmodule : tb_standard_timer_output_ctrl
